// file: src/dwg_pkg.sv
// dwg_pkg: register map, field layout and widths of the waveform generator
// assumes word-aligned AHB-Lite accesses from a single master
package dwg_pkg;
  // register byte addresses
  localparam logic [31:0] DWG_CFG_ADDR = 32'h4008_0014;
  localparam logic [31:0] DWG_LVL1_ADDR = 32'h4008_0018;
  localparam logic [31:0] DWG_LVL2_ADDR = 32'h4008_001c;
  localparam logic [31:0] DWG_HLD1_ADDR = 32'h4008_0020;
  localparam logic [31:0] DWG_RMP1_ADDR = 32'h4008_0024;
  localparam logic [31:0] DWG_HLD2_ADDR = 32'h4008_0028;
  localparam logic [31:0] DWG_RMP2_ADDR = 32'h4008_002c;
  localparam logic [31:0] DWG_FCW_ADDR = 32'h4008_0030;
  localparam logic [31:0] DWG_PHS_ADDR = 32'h4008_0034;
  localparam logic [31:0] DWG_DIR_ADDR = 32'h4008_0060;
  localparam logic [31:0] DWG_STAT_ADDR = 32'h4008_0064;
  // config fields and reset value
  localparam int DWG_RESTART_BIT = 0;
  localparam int DWG_TYPE_LSB = 1;
  localparam int DWG_OFFS_BIT = 4;
  localparam int DWG_GAIN_BIT = 5;
  localparam logic [31:0] DWG_CFG_RST = 32'h0000_0030;
  localparam logic [31:0] DWG_ZERO_RST = 32'h0000_0000;
  // field widths
  localparam int DWG_LVL_W = 12;
  localparam int DWG_TIME_W = 20;
  localparam int DWG_FCW_W = 19;
  localparam int DWG_PH_W = 20;
  // gain word is unsigned with this many fraction bits
  localparam int DWG_GAIN_FRAC = 14;
  // sine midscale and largest magnitude
  localparam logic [11:0] DWG_MID = 12'h800;
  localparam logic [11:0] DWG_MAG_MAX = 12'h7ff;
  typedef enum logic [1:0] {DWG_HOLD1, DWG_RAMP1, DWG_HOLD2, DWG_RAMP2}
    dwg_phase_t;
endpackage

// file: src/dwg_top.sv
// dwg_top: waveform generator feeding DAC codes, with AHB-Lite registers
// assumes one update pulse per DAC period and static calibration inputs
//
// Contract
// RULE_01: type field picks direct, sine or trapezoid
// RULE_02: restart bit restarts trapezoid at first hold
// RULE_03: restart bit clears itself after restart
// RULE_04: gain enable applies trimmed gain, resets one
// RULE_05: offset enable applies path offset, resets one
// RULE_06: twelve bit first level for first hold
// RULE_07: twelve bit second level for second hold
// RULE_08: first hold lasts programmed update periods
// RULE_09: first ramp lasts programmed update periods
// RULE_10: second hold lasts programmed update periods
// RULE_11: second ramp lasts programmed update periods
// RULE_12: sine frequency from nineteen bit control word
// RULE_13: twenty bit phase shift, zero means none
// RULE_14: trapezoid phases cycle in order, linear ramps
// RULE_15: phase accumulates per update, mapped to sine
`timescale 1ns/1ps
module dwg_top #(
  parameter int GAIN_W = 16,
  parameter int OFFS_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic dac_update_i,
  input wire logic atten_en_i,
  input wire logic [GAIN_W-1:0] factory_gain_value_i,
  input wire logic [OFFS_W-1:0] calibrated_offset_unity_i,
  input wire logic [OFFS_W-1:0] calibrated_offset_attenuated_i,
  output logic [dwg_pkg::DWG_LVL_W-1:0] dac_code_o
);
  import dwg_pkg::*;

  logic wr_pend_r;
  logic rd_pend_r;
  logic [31:0] addr_r;
  logic gain_en_r;
  logic offs_en_r;
  logic [1:0] type_r;
  logic restart_r;
  logic restart_nxt;
  logic [11:0] first_level_code_r;
  logic [11:0] second_level_code_r;
  logic [11:0] direct_r;
  logic [19:0] hold1_r;
  logic [19:0] ramp1_r;
  logic [19:0] hold2_r;
  logic [19:0] ramp2_r;
  logic [18:0] sine_frequency_control_r;
  logic [19:0] sine_phase_shift_value_r;
  logic [19:0] acc_r;
  logic [19:0] tcnt_r;
  dwg_phase_t phase_r;
  dwg_phase_t phase_nxt;
  logic [11:0] code_r;

  // a register is written in the data phase of its write
  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction

  // linear ramp from start toward stop after cnt of len periods
  function automatic logic [11:0] ramp(input logic [11:0] start,
    input logic [11:0] stop, input logic [19:0] cnt,
    input logic [19:0] len);
    logic signed [12:0] d;
    logic signed [33:0] p;
    logic signed [33:0] q;
    d = 13'($signed({1'b0, stop}) - $signed({1'b0, start}));
    p = 34'(d * $signed({1'b0, cnt}));
    q = (len == 20'h0_0000) ? 34'sd0 : p / $signed({14'h0, len});
    ramp = 12'($signed({1'b0, start}) + q[12:0]);
  endfunction

  // parabolic sine: midscale plus or minus x*(2048-x)/512
  function automatic logic [11:0] sine(input logic [19:0] p);
    logic [10:0] x;
    logic [22:0] m;
    logic [11:0] mag;
    x = p[18:8];
    m = 23'(x) * 23'(12'h800 - {1'b0, x});
    mag = m[20:9];
    if (mag > DWG_MAG_MAX)
    begin
      mag = DWG_MAG_MAX;
    end
    sine = p[19] ? DWG_MID - mag : DWG_MID + mag;
  endfunction

  // bus slave: zero wait states, always OKAY
  wire take = hsel_i & hready_i & htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // address phase capture
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= DWG_ZERO_RST;
    end
    else
    begin
      wr_pend_r <= take & hwrite_i;
      rd_pend_r <= take & ~hwrite_i;
      if (take)
      begin
        addr_r <= haddr_i;
      end
    end
  end

  // write strobes per register
  wire wr_cfg = wr_pend_r & hit(addr_r, DWG_CFG_ADDR);
  wire wr_lvl1 = wr_pend_r & hit(addr_r, DWG_LVL1_ADDR);
  wire wr_lvl2 = wr_pend_r & hit(addr_r, DWG_LVL2_ADDR);
  wire wr_hld1 = wr_pend_r & hit(addr_r, DWG_HLD1_ADDR);
  wire wr_rmp1 = wr_pend_r & hit(addr_r, DWG_RMP1_ADDR);
  wire wr_hld2 = wr_pend_r & hit(addr_r, DWG_HLD2_ADDR);
  wire wr_rmp2 = wr_pend_r & hit(addr_r, DWG_RMP2_ADDR);
  wire wr_fcw = wr_pend_r & hit(addr_r, DWG_FCW_ADDR);
  wire wr_phs = wr_pend_r & hit(addr_r, DWG_PHS_ADDR);
  wire wr_dir = wr_pend_r & hit(addr_r, DWG_DIR_ADDR);

  // restart pends one cycle; a new write in that cycle wins
  assign restart_nxt = wr_cfg ? hwdata_i[DWG_RESTART_BIT] : 1'b0; // RULE_03

  // configuration register
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      gain_en_r <= DWG_CFG_RST[DWG_GAIN_BIT]; // RULE_04
      offs_en_r <= DWG_CFG_RST[DWG_OFFS_BIT]; // RULE_05
      type_r <= DWG_CFG_RST[DWG_TYPE_LSB+:2];
      restart_r <= DWG_CFG_RST[DWG_RESTART_BIT];
    end
    else
    begin
      restart_r <= restart_nxt;
      if (wr_cfg)
      begin
        gain_en_r <= hwdata_i[DWG_GAIN_BIT];
        offs_en_r <= hwdata_i[DWG_OFFS_BIT];
        type_r <= hwdata_i[DWG_TYPE_LSB+:2];
      end
    end
  end

  // level and direct code registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      first_level_code_r <= DWG_ZERO_RST[11:0];
      second_level_code_r <= DWG_ZERO_RST[11:0];
      direct_r <= DWG_ZERO_RST[11:0];
    end
    else
    begin
      if (wr_lvl1)
        first_level_code_r <= hwdata_i[11:0]; // RULE_06
      if (wr_lvl2)
        second_level_code_r <= hwdata_i[11:0]; // RULE_07
      if (wr_dir)
        direct_r <= hwdata_i[11:0];
    end
  end

  // phase time registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold1_r <= DWG_ZERO_RST[19:0];
      ramp1_r <= DWG_ZERO_RST[19:0];
      hold2_r <= DWG_ZERO_RST[19:0];
      ramp2_r <= DWG_ZERO_RST[19:0];
    end
    else
    begin
      if (wr_hld1)
        hold1_r <= hwdata_i[19:0]; // RULE_08
      if (wr_rmp1)
        ramp1_r <= hwdata_i[19:0]; // RULE_09
      if (wr_hld2)
        hold2_r <= hwdata_i[19:0]; // RULE_10
      if (wr_rmp2)
        ramp2_r <= hwdata_i[19:0]; // RULE_11
    end
  end

  // sine control registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sine_frequency_control_r <= DWG_ZERO_RST[18:0];
      sine_phase_shift_value_r <= DWG_ZERO_RST[19:0];
    end
    else
    begin
      if (wr_fcw)
        sine_frequency_control_r <= hwdata_i[18:0]; // RULE_12
      if (wr_phs)
        sine_phase_shift_value_r <= hwdata_i[19:0]; // RULE_13
    end
  end

  // read mux in the data phase; unmapped reads give zero
  wire [31:0] cfg_rd = {26'h0, gain_en_r, offs_en_r, 1'b0, type_r,
    restart_r};
  wire [31:0] stat_rd = {18'h0, phase_r, code_r};
  always_comb
  begin
    hrdata_o = 32'h0000_0000;
    if (rd_pend_r)
    begin
      case (addr_r)
        DWG_CFG_ADDR: hrdata_o = cfg_rd;
        DWG_LVL1_ADDR: hrdata_o = {20'h0, first_level_code_r};
        DWG_LVL2_ADDR: hrdata_o = {20'h0, second_level_code_r};
        DWG_HLD1_ADDR: hrdata_o = {12'h0, hold1_r};
        DWG_RMP1_ADDR: hrdata_o = {12'h0, ramp1_r};
        DWG_HLD2_ADDR: hrdata_o = {12'h0, hold2_r};
        DWG_RMP2_ADDR: hrdata_o = {12'h0, ramp2_r};
        DWG_FCW_ADDR: hrdata_o = {13'h0, sine_frequency_control_r};
        DWG_PHS_ADDR: hrdata_o = {12'h0, sine_phase_shift_value_r};
        DWG_DIR_ADDR: hrdata_o = {20'h0, direct_r};
        DWG_STAT_ADDR: hrdata_o = stat_rd;
        default: hrdata_o = 32'h0000_0000;
      endcase
    end
  end

  // trapezoid: length of the current phase and next phase
  logic [19:0] cur_len;
  always_comb
  begin
    case (phase_r)
      DWG_HOLD1: cur_len = hold1_r; // RULE_08
      DWG_RAMP1: cur_len = ramp1_r; // RULE_09
      DWG_HOLD2: cur_len = hold2_r; // RULE_10
      DWG_RAMP2: cur_len = ramp2_r; // RULE_11
      default: cur_len = hold1_r;
    endcase
  end
  always_comb
  begin
    case (phase_r)
      DWG_HOLD1: phase_nxt = DWG_RAMP1; // RULE_14
      DWG_RAMP1: phase_nxt = DWG_HOLD2;
      DWG_HOLD2: phase_nxt = DWG_RAMP2;
      DWG_RAMP2: phase_nxt = DWG_HOLD1;
      default: phase_nxt = DWG_HOLD1;
    endcase
  end
  wire trap_on = (type_r == 2'b11);
  wire [20:0] cnt_inc = {1'b0, tcnt_r} + 21'h00_0001;
  wire phase_done = cnt_inc >= {1'b0, cur_len};

  // trapezoid sequencer, counts update periods
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      phase_r <= DWG_HOLD1;
      tcnt_r <= DWG_ZERO_RST[19:0];
    end
    else if (restart_r)
    begin
      phase_r <= DWG_HOLD1; // RULE_02
      tcnt_r <= DWG_ZERO_RST[19:0];
    end
    else if (trap_on && dac_update_i)
    begin
      phase_r <= phase_done ? phase_nxt : phase_r; // RULE_14
      tcnt_r <= phase_done ? DWG_ZERO_RST[19:0] : cnt_inc[19:0];
    end
  end

  // trapezoid level for the current phase
  logic [11:0] trap_code;
  always_comb
  begin
    case (restart_r ? DWG_HOLD1 : phase_r) // RULE_02
      DWG_HOLD1: trap_code = first_level_code_r; // RULE_06
      DWG_RAMP1: trap_code = ramp(first_level_code_r,
        second_level_code_r, tcnt_r, ramp1_r); // RULE_14
      DWG_HOLD2: trap_code = second_level_code_r; // RULE_07
      DWG_RAMP2: trap_code = ramp(second_level_code_r,
        first_level_code_r, tcnt_r, ramp2_r); // RULE_14
      default: trap_code = first_level_code_r;
    endcase
  end

  // sine phase accumulator
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      acc_r <= DWG_ZERO_RST[19:0];
    else if (dac_update_i)
      acc_r <= acc_r + {1'b0, sine_frequency_control_r}; // RULE_15
  end
  wire [19:0] sine_ph = acc_r + sine_phase_shift_value_r; // RULE_13
  wire [11:0] sine_code = sine(sine_ph); // RULE_15

  // source select by waveform type
  wire [11:0] src_code = !type_r[1] ? direct_r :
    (type_r[0] ? trap_code : sine_code); // RULE_01

  // gain then offset correction, saturated to the code range
  wire [27:0] gprod = 28'(src_code) * 28'(factory_gain_value_i);
  wire [14:0] gval = gain_en_r ? {1'b0, gprod[27:14]} :
    {3'h0, src_code}; // RULE_04
  wire [OFFS_W-1:0] offs_sel = atten_en_i ?
    calibrated_offset_attenuated_i : calibrated_offset_unity_i;
  wire signed [16:0] offs_ext = offs_en_r ?
    17'($signed(offs_sel)) : 17'sd0; // RULE_05
  wire signed [16:0] sum = $signed({2'b00, gval}) + offs_ext;
  wire [11:0] sat_code = sum[16] ? 12'h000 :
    (sum > 17'sd4095 ? 12'hfff : sum[11:0]);

  // output code, moved at each update or on restart
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      code_r <= DWG_ZERO_RST[11:0];
    else if (dac_update_i || restart_r)
      code_r <= sat_code;
  end
  assign dac_code_o = code_r;
endmodule

// file: tb/dwg_chk.sv
// dwg_chk: bus and output assertions on the top ports
// assumes bind into dwg_top, single word transfers
`timescale 1ns/1ps
module dwg_chk
  import dwg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic dac_update_i,
  input wire logic [11:0] dac_code_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic rd, wr, rcfg, rstat, cfg_wph_r;
  // address phases taken by the slave
  assign rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  assign rcfg = rd && haddr_i == DWG_CFG_ADDR;
  assign rstat = rd && haddr_i == DWG_STAT_ADDR;
  // marks a config write data phase
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cfg_wph_r <= 1'b0;
    else
      cfg_wph_r <= wr && haddr_i == DWG_CFG_ADDR;
  end
  property p_ready;
    hreadyout_o && !hresp_o;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or okay");
  property p_idle_rd;
    !$past(rd) |-> hrdata_o == 32'h0000_0000;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("stray read data");
  property p_cfg_rsv;
    $past(rcfg) |-> hrdata_o[31:6] == '0 && !hrdata_o[3];
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("config spare");
  property p_lvl_w;
    $past(rd && haddr_i[31:3] == DWG_LVL1_ADDR[31:3]) |->
      hrdata_o[31:12] == '0;
  endproperty
  a_lvl_w: assert property (p_lvl_w) else $error("level width");
  property p_clr;
    $past(rcfg) && !$past(cfg_wph_r) |-> !hrdata_o[0];
  endproperty
  a_clr: assert property (p_clr) else $error("restart stuck");
  property p_cause;
    $changed(dac_code_o) |->
      $past(dac_update_i) || $past(wr && haddr_i == DWG_CFG_ADDR, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("code moved");
  property p_stat;
    $past(rstat) |-> hrdata_o[11:0] == dac_code_o && hrdata_o[31:14] == '0;
  endproperty
  a_stat: assert property (p_stat) else $error("status code");
  property p_hold;
    !cfg_wph_r ##1 !dac_update_i |=> $stable(dac_code_o);
  endproperty
  a_hold: assert property (p_hold) else $error("code unstable");
  c_restart: cover property (cfg_wph_r);
  c_update: cover property ($past(dac_update_i) && $changed(dac_code_o));
  c_stat: cover property ($past(rstat));
endmodule
bind dwg_top dwg_chk u_dwg_chk (.sys_clk_i, .rstn_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .dac_update_i, .dac_code_o);

// file: tb/dwg_dac_model.sv
// dwg_dac_model: far-side DAC, one update strobe per request
// assumes req_i is one cycle wide and gap_i held while waiting
`timescale 1ns/1ps
module dwg_dac_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic [3:0] gap_i,
  output logic upd_o
);
  logic [3:0] cnt_r;
  logic busy_r;
  // waits gap cycles, prompt or slow, then strobes once
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      upd_o <= 1'b0;
    end
    else
    begin
      upd_o <= busy_r && cnt_r == 4'h0;
      if (req_i)
        cnt_r <= gap_i;
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      busy_r <= req_i || (busy_r && cnt_r != 4'h0);
    end
  end
endmodule

// file: tb/dwg_top_tb.sv
// dwg_top_tb: random and corner tests of modes, trapezoid, sine
// assumes zero-wait slave and static calibration between updates
`timescale 1ns/1ps
module dwg_top_tb;
  import dwg_pkg::*;
  logic sys_clk_i = 0, rstn_i = 0, hsel_i = 0, hwrite_i = 0, req = 0;
  logic atten_en_i = 0, hreadyout_o, hresp_o, upd;
  logic [1:0] htrans_i = 0;
  logic [3:0] gap = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd_d, cf;
  logic [15:0] gain = 16'h4000;
  logic [11:0] ofs_u = 0, ofs_a = 0, dac_code_o, l1, l2;
  logic [31:0] ad[10] = '{DWG_CFG_ADDR, DWG_LVL1_ADDR, DWG_LVL2_ADDR,
    DWG_HLD1_ADDR, DWG_RMP1_ADDR, DWG_HLD2_ADDR, DWG_RMP2_ADDR,
    DWG_FCW_ADDR, DWG_PHS_ADDR, DWG_DIR_ADDR};
  int mk[10] = '{'h36, 'hfff, 'hfff, 'hfffff, 'hfffff, 'hfffff, 'hfffff,
    'h7ffff, 'hfffff, 'hfff};
  int n_errors = 0, check_count = 0, len[4], ph, cnt, e, acc, fcw, phs;
  always #5 sys_clk_i = ~sys_clk_i;
  dwg_top u_dwg_top (.sys_clk_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .dac_update_i(upd), .atten_en_i,
    .factory_gain_value_i(gain), .calibrated_offset_unity_i(ofs_u),
    .calibrated_offset_attenuated_i(ofs_a), .dac_code_o);
  dwg_dac_model u_dwg_dac_model (.sys_clk_i, .rstn_i, .req_i(req),
    .gap_i(gap), .upd_o(upd));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input int d);
    hsel_i <= 1;
    htrans_i <= 2'b10;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    rd_d = hrdata_o;
  endtask
  task automatic chk(input logic [31:0] a, input int exp);
    bus(0, a, 0);
    cmp(rd_d, exp);
  endtask
  // asks the DAC model for one update and waits it out
  task automatic step;
    gap <= 4'($urandom_range(0, 9));
    req <= 1;
    @(posedge sys_clk_i);
    req <= 0;
    for (int k = 0; k < 20 && upd !== 1'b1; k++) @(posedge sys_clk_i) #1;
    if (upd !== 1'b1) cmp(0, 1);
    @(posedge sys_clk_i) #1;
  endtask
  function automatic int corr(input int s, input logic [1:0] en);
    int g;
    g = en[1] ? (s * gain) >> 14 : s;
    if (en[0]) g += $signed(atten_en_i ? ofs_a : ofs_u);
    return g < 0 ? 0 : g > 4095 ? 4095 : g;
  endfunction
  function automatic int trap(input int p, input int c);
    int a, b;
    a = p < 2 ? l1 : l2;
    b = p < 2 ? l2 : l1;
    return p % 2 ? a + (b - a) * c / len[p] : a;
  endfunction
  function automatic int sine(input logic [19:0] p);
    int x, m;
    x = p[18:8];
    m = (x * (2048 - x)) >> 9;
    if (m > 2047) m = 2047;
    return p[19] ? 2048 - m : 2048 + m;
  endfunction
  task automatic finish_test;
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400_000;
    n_errors++;
    finish_test;
  end
  initial
  begin
    void'($urandom(32'hacbf));
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1;
    @(posedge sys_clk_i);
    chk(DWG_CFG_ADDR, DWG_CFG_RST);
    for (int i = 1; i < 10; i++) chk(ad[i], DWG_ZERO_RST);
    for (int i = 0; i < 10; i++)
    begin
      e = $urandom;
      bus(1, ad[i], e);
      chk(ad[i], e & mk[i]);
    end
    bus(1, 32'h4008_0050, 32'hffff_ffff);
    chk(32'h4008_0050, 0);
    // direct source with every correction setting, corner codes first
    for (int i = 0; i < 16; i++)
    begin
      gain <= 16'h3000 + 16'($urandom_range(0, 'h2000));
      ofs_u <= 12'($urandom);
      ofs_a <= 12'($urandom);
      atten_en_i <= 1'($urandom);
      l1 = i == 0 ? 12'hfff : i == 1 ? 12'h000 : 12'($urandom);
      cf = {26'h0, i[1:0], 2'b00, i[2], 1'b0};
      bus(1, DWG_DIR_ADDR, l1);
      bus(1, DWG_CFG_ADDR, cf);
      step;
      cmp(dac_code_o, corr(l1, cf[5:4]));
    end
    // trapezoid with a zero-length hold and a restart midway
    l1 = 12'($urandom);
    l2 = 12'($urandom);
    len = '{$urandom_range(0, 3), $urandom_range(1, 6), 0, 5};
    bus(1, DWG_LVL1_ADDR, l1);
    bus(1, DWG_LVL2_ADDR, l2);
    for (int i = 0; i < 4; i++) bus(1, ad[i + 3], len[i]);
    bus(1, DWG_CFG_ADDR, 32'h0000_0007);
    @(posedge sys_clk_i) #1;
    cmp(dac_code_o, l1);
    chk(DWG_CFG_ADDR, 32'h0000_0006);
    for (int j = 0; j < 50; j++)
    begin
      if (j == 30)
      begin
        bus(1, DWG_CFG_ADDR, 32'h0000_0007);
        {ph, cnt} = 0;
        @(posedge sys_clk_i) #1;
        cmp(dac_code_o, l1);
      end
      step;
      e = trap(ph, cnt);
      cmp(dac_code_o, e);
      if (cnt + 1 >= len[ph]) {ph, cnt} = {(ph + 1) % 4, 32'h0};
      else cnt++;
      chk(DWG_STAT_ADDR, (ph << 12) | e);
    end
    // sine after a second reset, so the accumulator starts at zero
    rstn_i <= 0;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1;
    @(posedge sys_clk_i);
    fcw = $urandom;
    phs = $urandom;
    bus(1, DWG_FCW_ADDR, fcw);
    bus(1, DWG_PHS_ADDR, phs);
    bus(1, DWG_CFG_ADDR, 32'h0000_0004);
    acc = 0;
    repeat (40)
    begin
      step;
      cmp(dac_code_o, sine(20'(acc + phs)));
      acc += fcw & 'h7ffff;
    end
    finish_test;
  end
endmodule
